// ===== nmes_defines.svh
// Constants of the network master error status block.
// Assumes inclusion by its bare name from the package, nmes_sync, nmes_loopback and nmes_top.
`ifndef NMES_DEFINES_SVH
`define NMES_DEFINES_SVH

// Register indexes; the byte address is four times the index
`define NMES_IDX_ERR_STATUS 8'h1D
`define NMES_IDX_IRQ_STATUS 8'h20
`define NMES_IDX_IRQ_MASK 8'h21
`define NMES_IDX_FINAL_STN 8'h22
`define NMES_IDX_LB_CTRL 8'h23

// Bit positions in the detailed error status word
`define NMES_B_LINK_SOME 0
`define NMES_B_LINK_ALL 1
`define NMES_B_REMOTE_IO 2
`define NMES_B_UNREG_STN 3
`define NMES_B_SPEED 4
`define NMES_B_RD_SETUP 6
`define NMES_B_NVMEM 7
`define NMES_B_SWITCH 8
`define NMES_B_HW 15
`define NMES_ERR_IMPL_MASK 16'h81DF

// Loopback control fields
`define NMES_LB_START_BIT 0
`define NMES_LB_BUSY_BIT 0
`define NMES_LB_DONE_BIT 1
`define NMES_LB_PASS_BIT 2

// Reset values
`define NMES_FINAL_STN_RST 7'h40
`define NMES_IRQ_MASK_RST 16'h0000

// Special-range station window
`define NMES_RD_STN_MIN 7'h31
`define NMES_RD_STN_MAX 7'h40

// Supported speed selector positions, one bit per position
`define NMES_SPEED_OK_MASK 8'h0F

// Loopback engine
`define NMES_LB_LAT 2
`define NMES_LB_LEN 9'h100
`define NMES_LFSR_SEED 8'hA5
`define NMES_LFSR_TAPS 8'hB8

// Width of the synchronised pin bundle
`define NMES_SYNC_W 163

`endif

// ===== nmes_pkg.sv
// Types shared by the network master error status design.
// Assumes nmes_defines.svh is on the include path.
`include "nmes_defines.svh"

package nmes_pkg;

	typedef enum logic [1:0] {
		NMES_LB_IDLE = 2'b00,
		NMES_LB_RUN = 2'b01,
		NMES_LB_DONE = 2'b10
	} nmes_lb_state_t;

	typedef struct packed {
		nmes_lb_state_t st;
		logic [7:0] lfsr;
		logic [8:0] count;
		logic [`NMES_LB_LAT-1:0] hist;
		logic tx;
		logic err;
		logic done;
		logic passed;
		logic pass_led;
		logic fail_led;
	} nmes_lb_t;

	typedef struct packed {
		logic [15:0] err;
		logic unreg_lat;
		logic speed_lat;
		logic rd_lat;
		logic nv_lat;
		logic sw_chg;
		logic hw_lat;
		logic [7:0] sw_ref;
		logic ref_valid;
		logic tm_prev;
		logic [15:0] irq_stat;
		logic [15:0] irq_mask;
		logic [6:0] final_stn;
		logic lb_start;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} nmes_top_t;

endpackage

// ===== nmes_sync.sv
// Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is quasi-static or needs no coherence with the others.
`include "nmes_defines.svh"

module nmes_sync
	import nmes_pkg::*;
#(
	parameter int W = 1
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} nmes_sync_t;

	nmes_sync_t s_reg;
	nmes_sync_t s_next;

	always_comb
	begin
		s_next.s1 = d;
		s_next.s2 = s_reg.s1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign q = s_reg.s2;
endmodule

// ===== nmes_loopback.sv
// Self-loopback test engine: sends a pseudo-random bit stream out on the
// loop path and checks it coming back after a fixed delay.
// Assumes the return bit arrives through the two-stage pin synchroniser.
`include "nmes_defines.svh"

module nmes_loopback
	import nmes_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic rx_sync,
	output logic tx,
	output logic busy,
	output logic done,
	output logic passed,
	output logic pass_led,
	output logic fail_led
);
	nmes_lb_t s_reg;
	nmes_lb_t s_next;

	always_comb
	begin
		s_next = s_reg;
		s_next.done = 1'b0;
		case (s_reg.st)
			NMES_LB_RUN:
			begin
				s_next.lfsr = {s_reg.lfsr[6:0],
					^(s_reg.lfsr & `NMES_LFSR_TAPS)};
				s_next.tx = s_reg.lfsr[7];
				s_next.hist = {s_reg.hist[`NMES_LB_LAT-2:0], s_reg.tx};
				s_next.count = s_reg.count + 9'h001;
				// Only the internal loop is used; no remote station needed
				if (s_reg.count > 9'(`NMES_LB_LAT) &&
					rx_sync != s_reg.hist[`NMES_LB_LAT-1]) // R12
					s_next.err = 1'b1;
				if (s_reg.count == `NMES_LB_LEN)
				begin
					s_next.st = NMES_LB_DONE;
					s_next.done = 1'b1;
					s_next.passed = ~s_next.err;
					s_next.pass_led = ~s_next.err; // R13
					s_next.fail_led = s_next.err; // R13
				end
			end
			NMES_LB_IDLE, NMES_LB_DONE:
			begin
				if (start)
				begin
					s_next.st = NMES_LB_RUN;
					s_next.lfsr = `NMES_LFSR_SEED;
					s_next.count = 9'h000;
					s_next.err = 1'b0;
					s_next.passed = 1'b0;
					// Both indicators dark while the test runs
					s_next.pass_led = 1'b0; // R13
					s_next.fail_led = 1'b0; // R13
				end
			end
			default:
				s_next.st = NMES_LB_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign tx = s_reg.tx;
	assign busy = (s_reg.st == NMES_LB_RUN);
	assign done = s_reg.done;
	assign passed = s_reg.passed;
	assign pass_led = s_reg.pass_led;
	assign fail_led = s_reg.fail_led;
endmodule

// ===== nmes_top.sv
// Detailed error status word of a field-network master station, with an
// APB register slave, error interrupt and self-loopback test.
// Assumes status pins come from the link layer in another clock domain and
// that sys_rst is the power-on reset of the whole station.
//
// Function
// R1: One error class per bit, 1 means present
// R2: Bit 0 follows any per-station link error
// R3: Bit 1 set when every station's link failed
// R4: Bit 2 follows any per-station remote I/O error
// R5: Bit 3 set on unregistered station connection
// R6: Bit 3 self-clears below final, else needs reset
// R7: Bit 4 bad speed, held until power reset
// R8: Bit 6 special-range misuse, held until reset
// R9: Bit 7 clears with request; failures stay set
// R10: Bit 8 set on switch change while running
// R11: Bit 15 loopback fault, never self-clears
// R12: Loopback test needs no remote stations
// R13: Pass or fail indicator lit after test
// R14: Bits 5 and 9 to 14 read zero
//
// Register access over APB was decided locally.
`include "nmes_defines.svh"

module nmes_top
	import nmes_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [63:0] link_err_bits,
	input wire logic [63:0] rio_err_bits,
	input wire logic unreg_seen,
	input wire logic [6:0] unreg_num,
	input wire logic [2:0] speed_sel,
	input wire logic rd_present,
	input wire logic [6:0] rd_num,
	input wire logic four_point_mode,
	input wire logic nv_write_req,
	input wire logic config_mode,
	input wire logic nv_write_fail,
	input wire logic nv_read_fail,
	input wire logic [7:0] dip_sw,
	input wire logic link_running,
	input wire logic test_mode,
	input wire logic lb_rx,
	output logic lb_tx,
	output logic pass_led,
	output logic fail_led,
	output logic irq
);
	// One bit per selector position; a clear bit marks a bad setting
	localparam logic [7:0] SPEED_OK = `NMES_SPEED_OK_MASK;

	// Matches a word-aligned byte address against a register index
	function automatic logic idx_match(input logic [11:0] a,
		input logic [7:0] idx);
		return a == {2'h0, idx, 2'h0};
	endfunction

	// Stations 1..n occupy bits 0..n-1 of the per-station words
	function automatic logic [63:0] stn_mask(input logic [6:0] n);
		logic [64:0] one;
		one = 65'h1;
		return 64'((one << n) - 65'h1);
	endfunction

	nmes_top_t s_reg;
	nmes_top_t s_next;

	logic [`NMES_SYNC_W-1:0] pin_raw;
	logic [`NMES_SYNC_W-1:0] pin_s;
	logic [63:0] link_s;
	logic [63:0] rio_s;
	logic unreg_seen_s;
	logic [6:0] unreg_num_s;
	logic [2:0] speed_s;
	logic rd_present_s;
	logic [6:0] rd_num_s;
	logic four_pt_s;
	logic nv_req_s;
	logic cfg_s;
	logic nv_wfail_s;
	logic nv_rfail_s;
	logic [7:0] dip_s;
	logic running_s;
	logic test_mode_s;
	logic lb_rx_s;

	logic lb_busy;
	logic lb_done;
	logic lb_passed;

	logic setup;
	logic wr;
	logic [63:0] mask_all;
	logic all_down;
	logic rd_bad;
	logic [15:0] err_raw;
	logic [15:0] rise;
	logic [15:0] w1c;
	logic [31:0] rdata;
	logic hit;
	logic sel_err;
	logic sel_ist;
	logic sel_imk;
	logic sel_fin;
	logic sel_lbc;
	logic unreg_hold;
	logic speed_bad;
	logic nv_fail;
	logic lb_fail;

	// Multi-bit numbers are assumed stable while their strobe is high
	assign pin_raw = {
		link_err_bits,
		rio_err_bits,
		unreg_seen,
		unreg_num,
		speed_sel,
		rd_present,
		rd_num,
		four_point_mode,
		nv_write_req,
		config_mode,
		nv_write_fail,
		nv_read_fail,
		dip_sw,
		link_running,
		test_mode,
		lb_rx
	};

	nmes_sync #(.W(`NMES_SYNC_W)) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d(pin_raw),
		.q(pin_s)
	);

	assign {
		link_s,
		rio_s,
		unreg_seen_s,
		unreg_num_s,
		speed_s,
		rd_present_s,
		rd_num_s,
		four_pt_s,
		nv_req_s,
		cfg_s,
		nv_wfail_s,
		nv_rfail_s,
		dip_s,
		running_s,
		test_mode_s,
		lb_rx_s
	} = pin_s;

	nmes_loopback u_lb (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.start(s_reg.lb_start),
		.rx_sync(lb_rx_s),
		.tx(lb_tx),
		.busy(lb_busy),
		.done(lb_done),
		.passed(lb_passed),
		.pass_led(pass_led),
		.fail_led(fail_led)
	);

	always_comb
	begin
		s_next = s_reg;

		// Error source evaluation
		mask_all = stn_mask(s_reg.final_stn);
		all_down = (s_reg.final_stn != 7'h00) &&
			((link_s & mask_all) == mask_all); // R3
		rd_bad = rd_present_s && (rd_num_s < `NMES_RD_STN_MIN ||
			rd_num_s > `NMES_RD_STN_MAX || four_pt_s); // R8

		// Equal to the final number is held like a higher one
		unreg_hold = unreg_seen_s && unreg_num_s >= s_reg.final_stn; // R6
		speed_bad = !SPEED_OK[speed_s]; // R7
		nv_fail = nv_wfail_s || nv_rfail_s; // R9
		lb_fail = lb_done && !lb_passed; // R11

		// Latches below are released only by the power-on reset
		if (unreg_hold)
		begin
			s_next.unreg_lat = 1'b1; // R6
		end
		if (speed_bad)
		begin
			s_next.speed_lat = 1'b1; // R7
		end
		if (rd_bad)
		begin
			s_next.rd_lat = 1'b1; // R8
		end
		if (nv_fail)
		begin
			s_next.nv_lat = 1'b1; // R9
		end
		if (lb_fail)
		begin
			s_next.hw_lat = 1'b1; // R11
		end

		// Switch reference is caught on the first cycle after reset
		if (!s_reg.ref_valid)
		begin
			s_next.ref_valid = 1'b1;
			s_next.sw_ref = dip_s;
		end
		if (s_reg.ref_valid && dip_s == s_reg.sw_ref)
		begin
			s_next.sw_chg = 1'b0;
		end
		else if (s_reg.ref_valid && running_s && dip_s != s_reg.sw_ref)
		begin
			s_next.sw_chg = 1'b1; // R10
		end

		err_raw = 16'h0000;
		err_raw[`NMES_B_LINK_SOME] = |link_s; // R2
		err_raw[`NMES_B_LINK_ALL] = all_down; // R3
		err_raw[`NMES_B_REMOTE_IO] = |rio_s; // R4
		// Low station numbers follow the live condition
		err_raw[`NMES_B_UNREG_STN] = unreg_seen_s || s_reg.unreg_lat; // R5
		err_raw[`NMES_B_SPEED] = s_reg.speed_lat; // R7
		err_raw[`NMES_B_RD_SETUP] = s_reg.rd_lat; // R8
		err_raw[`NMES_B_NVMEM] = (nv_req_s && !cfg_s) || s_reg.nv_lat; // R9
		err_raw[`NMES_B_SWITCH] = s_reg.sw_chg; // R10
		err_raw[`NMES_B_HW] = s_reg.hw_lat; // R11
		s_next.err = err_raw & `NMES_ERR_IMPL_MASK; // R1 R14

		// APB: one access cycle, answer registered at the setup edge
		setup = psel && !penable;
		wr = psel && penable && s_reg.pready && pwrite && !s_reg.pslverr;
		// Each mapped word is decoded once here
		sel_err = idx_match(paddr, `NMES_IDX_ERR_STATUS);
		sel_ist = idx_match(paddr, `NMES_IDX_IRQ_STATUS);
		sel_imk = idx_match(paddr, `NMES_IDX_IRQ_MASK);
		sel_fin = idx_match(paddr, `NMES_IDX_FINAL_STN);
		sel_lbc = idx_match(paddr, `NMES_IDX_LB_CTRL);
		// Unmapped addresses answer with an error and change nothing
		hit = sel_err ||
			sel_ist ||
			sel_imk ||
			sel_fin ||
			sel_lbc;

		// Unused and reserved bits read as zero
		rdata = 32'h0000_0000;
		if (sel_err)
		begin
			rdata[15:0] = s_reg.err; // R14
		end
		else if (sel_ist)
		begin
			rdata[15:0] = s_reg.irq_stat;
		end
		else if (sel_imk)
		begin
			rdata[15:0] = s_reg.irq_mask;
		end
		else if (sel_fin)
		begin
			rdata[6:0] = s_reg.final_stn;
		end
		else if (sel_lbc)
		begin
			rdata[`NMES_LB_BUSY_BIT] = lb_busy;
			rdata[`NMES_LB_DONE_BIT] = pass_led || fail_led;
			rdata[`NMES_LB_PASS_BIT] = pass_led;
		end

		s_next.pready = setup;
		s_next.pslverr = setup && !hit;
		s_next.prdata = (setup && !pwrite && hit) ? rdata : 32'h0000_0000;

		// Writes land on the edge that completes the access
		w1c = 16'h0000;
		s_next.lb_start = 1'b0;
		if (wr && sel_ist)
		begin
			w1c = pwdata[15:0] & `NMES_ERR_IMPL_MASK;
		end
		if (wr && sel_imk)
		begin
			s_next.irq_mask = pwdata[15:0] & `NMES_ERR_IMPL_MASK;
		end
		if (wr && sel_fin)
		begin
			s_next.final_stn = pwdata[6:0];
		end
		if (wr && sel_lbc && pwdata[`NMES_LB_START_BIT])
		begin
			s_next.lb_start = 1'b1;
		end

		// Test-mode pin entering also launches the loopback test
		s_next.tm_prev = test_mode_s;
		if (test_mode_s && !s_reg.tm_prev)
		begin
			s_next.lb_start = 1'b1;
		end

		// A new error in the clearing cycle is kept: set beats clear
		rise = s_next.err & ~s_reg.err;
		s_next.irq_stat = (s_reg.irq_stat & ~w1c) | rise;
		s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			s_reg <= '0;
			s_reg.final_stn <= `NMES_FINAL_STN_RST;
			s_reg.irq_mask <= `NMES_IRQ_MASK_RST;
		end
		else
			s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign irq = s_reg.irq;
endmodule

// ===== nmes_properties.sv
// Port-level assertions for the error status block.
// Assumes binding to nmes_top; one clock domain, clk_sys.
module nmes_properties
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [63:0] link_err_bits,
	input wire logic pass_led,
	input wire logic fail_led,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic mapped;
	assign mapped = paddr inside {12'h074, 12'h080, 12'h084, 12'h088, 12'h08C};
	sequence setup_s; psel && !penable; endsequence
	sequence st_rd_s; setup_s ##0 !pwrite && paddr == 12'h074; endsequence
	// Six samples cover the two sync stages plus the status update
	sequence link_on_s; (|link_err_bits)[*6]; endsequence
	sequence link_off_s; (link_err_bits == 64'h0)[*6]; endsequence

	apb_answer_a: assert property (setup_s |=> pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	unmapped_err_a: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	idle_zero_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	reserved_zero_a: assert property (st_rd_s |=>
		(prdata & 32'hFFFF7E20) == 32'h0)
		else $error("reserved status bits set");
	link_set_a: assert property (link_on_s ##0 st_rd_s |=> prdata[0])
		else $error("link summary bit missing");
	link_clear_a: assert property (link_off_s ##0 st_rd_s |=> !prdata[0])
		else $error("link summary bit stuck");
	led_excl_a: assert property (!(pass_led && fail_led))
		else $error("both indicators lit");
	reset_quiet_a: assert property ($fell(sys_rst) |->
		!pready && !irq && !pass_led && !fail_led)
		else $error("outputs active after reset");
endmodule

bind nmes_top nmes_properties u_props (.clk_sys, .sys_rst, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .link_err_bits, .pass_led,
	.fail_led, .irq);

// ===== nmes_stations.sv
// Model of the remote stations and of the loop return path.
// Assumes the bench changes its commands right after a rising edge.
module nmes_stations
(
	input wire logic [63:0] down_cmd,
	input wire logic [63:0] rio_cmd,
	input wire logic cut_cmd,
	input wire logic loop_fault,
	input wire logic lb_tx,
	output logic [63:0] link_err_bits,
	output logic [63:0] rio_err_bits,
	output logic lb_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// A cut supply drops every station at once
	assign link_err_bits = cut_cmd ? 64'hFFFFFFFFFFFFFFFF : down_cmd;
	// A station off the link cannot report its I/O state
	assign rio_err_bits = rio_cmd & ~link_err_bits;
	// No station sits on the loop; a fault inverts every bit
	assign lb_rx = lb_tx ^ loop_fault;
endmodule

// ===== network_master_error_status_tb.sv
// Self-checking bench for the network master error status block.
// Assumes nmes_top, its package and the station model are compiled first.
module network_master_error_status_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import nmes_pkg::*;
	logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err_seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] link_err_bits, rio_err_bits, down_cmd, rio_cmd;
	logic unreg_seen, rd_present, four_point_mode, nv_write_req, config_mode;
	logic nv_write_fail, nv_read_fail, link_running, test_mode, lb_rx, lb_tx;
	logic pass_led, fail_led, irq, cut_cmd, loop_fault;
	logic [6:0] unreg_num, rd_num;
	logic [2:0] speed_sel;
	logic [7:0] dip_sw;
	int error_cnt, check_count;

	nmes_top dut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .link_err_bits, .rio_err_bits,
		.unreg_seen, .unreg_num, .speed_sel, .rd_present, .rd_num,
		.four_point_mode, .nv_write_req, .config_mode, .nv_write_fail,
		.nv_read_fail, .dip_sw, .link_running, .test_mode, .lb_rx, .lb_tx,
		.pass_led, .fail_led, .irq);
	nmes_stations stn (.down_cmd, .rio_cmd, .cut_cmd, .loop_fault, .lb_tx,
		.link_err_bits, .rio_err_bits, .lb_rx);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			error_cnt++;
			report_and_stop();
		end
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// An idle edge keeps a following call from reusing this time step
		tick(1);
	endtask

	task automatic err_is(input logic [31:0] e);
		tick(5);
		apb(1'b0, 12'h074, 32'h0);
		check(rd, e);
	endtask

	task automatic wait_done();
		int i;
		tick(8);
		check({30'h0, pass_led, fail_led}, 32'h0);
		for (i = 0; i < 400; i++)
		begin
			@(posedge clk_sys);
			if (pass_led | fail_led)
				break;
		end
		if (i == 400)
		begin
			error_cnt++;
			report_and_stop();
		end
		tick(2);
	endtask

	task automatic t_regs();
		apb(1'b0, 12'h088, 32'h0);
		check(rd, 32'h40);
		apb(1'b1, 12'h074, 32'hFFFF);
		err_is(32'h0);
		apb(1'b0, 12'h090, 32'h0);
		check({31'h0, err_seen}, 32'h1);
		$display("regs test done");
	endtask

	task automatic t_link();
		apb(1'b1, 12'h084, 32'h1);
		down_cmd <= 64'h10;
		err_is(32'h1);
		check({31'h0, irq}, 32'h1);
		cut_cmd <= 1'b1;
		err_is(32'h3);
		cut_cmd <= 1'b0;
		down_cmd <= 64'h0;
		rio_cmd <= 64'h8000000000000000;
		err_is(32'h4);
		apb(1'b1, 12'h080, 32'h7);
		apb(1'b0, 12'h080, 32'h0);
		check({rd[30:0], irq}, 32'h0);
		rio_cmd <= 64'h0;
		apb(1'b1, 12'h088, 32'h4);
		down_cmd <= 64'hF;
		err_is(32'h3);
		down_cmd <= 64'h7;
		err_is(32'h1);
		down_cmd <= 64'h0;
		$display("link test done");
	endtask

	task automatic t_held();
		unreg_num <= 7'h3;
		unreg_seen <= 1'b1;
		err_is(32'h8);
		unreg_seen <= 1'b0;
		err_is(32'h0);
		unreg_num <= 7'h4;
		unreg_seen <= 1'b1;
		tick(5);
		unreg_seen <= 1'b0;
		speed_sel <= 3'h4;
		tick(5);
		speed_sel <= 3'h3;
		rd_num <= 7'h30;
		rd_present <= 1'b1;
		tick(5);
		rd_present <= 1'b0;
		err_is(32'h58);
		nv_write_req <= 1'b1;
		err_is(32'hD8);
		config_mode <= 1'b1;
		err_is(32'h58);
		nv_write_req <= 1'b0;
		config_mode <= 1'b0;
		nv_write_fail <= 1'b1;
		tick(2);
		nv_write_fail <= 1'b0;
		link_running <= 1'b1;
		dip_sw <= 8'h1;
		err_is(32'h1D8);
		dip_sw <= 8'h0;
		err_is(32'hD8);
		link_running <= 1'b0;
		sys_rst <= 1'b1;
		tick(3);
		sys_rst <= 1'b0;
		err_is(32'h0);
		rd_num <= 7'h31;
		four_point_mode <= 1'b1;
		rd_present <= 1'b1;
		nv_read_fail <= 1'b1;
		tick(2);
		rd_present <= 1'b0;
		four_point_mode <= 1'b0;
		nv_read_fail <= 1'b0;
		err_is(32'hC0);
		sys_rst <= 1'b1;
		tick(3);
		sys_rst <= 1'b0;
		err_is(32'h0);
		$display("held test done");
	endtask

	task automatic t_loop();
		apb(1'b1, 12'h08C, 32'h1);
		wait_done();
		apb(1'b0, 12'h08C, 32'h0);
		check(rd, 32'h6);
		loop_fault <= 1'b1;
		test_mode <= 1'b1;
		wait_done();
		check({30'h0, pass_led, fail_led}, 32'h1);
		loop_fault <= 1'b0;
		test_mode <= 1'b0;
		err_is(32'h8000);
		apb(1'b1, 12'h08C, 32'h1);
		wait_done();
		check({30'h0, pass_led, fail_led}, 32'h2);
		err_is(32'h8000);
		$display("loop test done");
	endtask

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, down_cmd, rio_cmd, cut_cmd,
			loop_fault, unreg_seen, unreg_num, speed_sel, rd_present, rd_num,
			four_point_mode, nv_write_req, config_mode, nv_write_fail,
			nv_read_fail, dip_sw, link_running, test_mode} = '0;
		error_cnt = 0;
		check_count = 0;
		sys_rst = 1'b1;
		tick(12);
		sys_rst <= 1'b0;
		tick(6);
		t_regs();
		t_link();
		t_held();
		t_loop();
		report_and_stop();
	end
endmodule
